/* bench/ppe_board.sv */
// Board model for the shared port pins
`default_nettype none
module ppe_board (
    input wire logic [2:0] open_drain_port_oe,
    input wire logic [2:0] od_x,
    input wire logic [7:0] pullup_port_a_oe,
    input wire logic [7:0] pullup_port_a_out,
    input wire logic [7:0] pa_x,
    output logic [2:0] open_drain_port_in,
    output logic [7:0] pullup_port_a_in
);
    timeunit 1ns; timeprecision 1ns;
    // ==========
    // A driven pin wins over the board level
    assign open_drain_port_in = ~open_drain_port_oe & od_x;
    assign pullup_port_a_in = pullup_port_a_oe & pullup_port_a_out
        | ~pullup_port_a_oe & pa_x;
endmodule // ppe_board
`default_nettype wire

/* bench/ppe_chk.sv */
// Checker on the port pin drive enables
`default_nettype none
module ppe_chk (
    input wire clk,
    input wire rst,
    input wire [2:0] open_drain_port_oe,
    input wire [2:0] open_drain_latch,
    input wire [7:0] pullup_port_a_oe,
    input wire [7:0] pullup_port_b_oe,
    input wire prog_state,
    input wire verify_mode
);
    timeunit 1ns; timeprecision 1ns;
    // ==========
    // Enables are combinational, so each edge is fair game
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence prog_s; prog_state; endsequence
    od_float_a: assert property (!prog_state |-> open_drain_port_oe[2] != open_drain_latch[2])
        else $error("od bit 2");
    od_pull_a: assert property (!prog_state |->
        (open_drain_port_oe[1:0] | open_drain_latch[1:0]) == 2'h3) else $error("od pull");
    od_quiet_a: assert property (prog_s |-> open_drain_port_oe == 3'h0)
        else $error("od driven");
    b_quiet_a: assert property (prog_s |-> pullup_port_b_oe == 8'h00)
        else $error("b driven");
    a_take_a: assert property (prog_s ##0 !verify_mode |-> pullup_port_a_oe == 8'h00)
        else $error("a driven");
    a_give_a: assert property (prog_s ##0 verify_mode |-> pullup_port_a_oe == 8'hFF)
        else $error("a idle");
    prog_hold_a: assert property (prog_s |=> prog_s) else $error("prog lost");
    vfy_rst_a: assert property ($fell(rst) |-> verify_mode) else $error("mode");
endmodule // ppe_chk
`default_nettype wire

/* bench/ppe_port_pins_test.sv */
// Bench for the port pins and program entry block
`default_nettype none
module ppe_port_pins_test;
    timeunit 1ns; timeprecision 1ns;
    // ==========
    // First scenario preset, hidden by reset
    logic clk = 0, rst = 1, osc_input_clock = 0, reset_pin = 0, i2c_enable = 1;
    logic i2c_scl_drive = 0, i2c_sda_drive = 1;
    logic [2:0] open_drain_latch = 3'h3, od_x = 3'h7;
    logic [7:0] pullup_port_a_latch = 8'hF0, pa_x = 8'h5F, eprom_rdata = 8'hC3;
    logic [7:0] pullup_port_b_latch = 8'hFF, pullup_port_b_in = 8'hE7;
    wire [2:0] open_drain_port_in, open_drain_port_out, open_drain_port_oe;
    wire [2:0] open_drain_port_read;
    wire [7:0] pullup_port_a_in, pullup_port_a_out, pullup_port_a_oe, pullup_port_a_read;
    wire [7:0] pullup_port_b_out, pullup_port_b_oe, pullup_port_b_read, prog_data;
    wire ext_irq_a, ext_irq_b, counter_ext_input, device_reset, prog_state, verify_mode;
    wire [10:0] eprom_addr;
    int mismatches = 0, n_checks = 0;
    localparam logic [9:0] KEY = 10'h2A5;
    ppe_port_pins #(.KEY(KEY)) dut (
        .clk(clk), .rst(rst), .osc_input_clock(osc_input_clock), .reset_pin(reset_pin),
        .open_drain_port_in(open_drain_port_in), .open_drain_port_out(open_drain_port_out),
        .open_drain_port_oe(open_drain_port_oe), .open_drain_latch(open_drain_latch),
        .i2c_enable(i2c_enable), .i2c_scl_drive(i2c_scl_drive), .i2c_sda_drive(i2c_sda_drive),
        .open_drain_port_read(open_drain_port_read),
        .pullup_port_a_in(pullup_port_a_in), .pullup_port_a_out(pullup_port_a_out),
        .pullup_port_a_oe(pullup_port_a_oe), .pullup_port_a_latch(pullup_port_a_latch),
        .pullup_port_a_read(pullup_port_a_read),
        .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .counter_ext_input(counter_ext_input),
        .pullup_port_b_in(pullup_port_b_in), .pullup_port_b_out(pullup_port_b_out),
        .pullup_port_b_oe(pullup_port_b_oe), .pullup_port_b_latch(pullup_port_b_latch),
        .pullup_port_b_read(pullup_port_b_read),
        .device_reset(device_reset), .prog_state(prog_state), .verify_mode(verify_mode),
        .eprom_addr(eprom_addr), .prog_data(prog_data), .eprom_rdata(eprom_rdata)
    );
    ppe_board board (
        .open_drain_port_oe(open_drain_port_oe), .od_x(od_x),
        .pullup_port_a_oe(pullup_port_a_oe), .pullup_port_a_out(pullup_port_a_out),
        .pa_x(pa_x), .open_drain_port_in(open_drain_port_in),
        .pullup_port_a_in(pullup_port_a_in)
    );
    always #50 clk = ~clk;
    task automatic ck(string w, logic [10:0] e, logic [10:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    // Two clocks a phase so the synchroniser sees each edge
    task automatic tick(logic lvl);
        reset_pin <= lvl;
        repeat (2) @(posedge clk);
        osc_input_clock <= 1;
        repeat (2) @(posedge clk);
        osc_input_clock <= 0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        repeat (6) @(negedge clk);
        ck("od read", 3'h2, open_drain_port_read);
        ck("a read", 8'h50, pullup_port_a_read);
        ck("alt in", 3'h2, {counter_ext_input, ext_irq_b, ext_irq_a});
        ck("b read", 8'hE7, pullup_port_b_read);
        @(posedge clk);
        repeat (23) tick(1);
        repeat (4) @(negedge clk);
        ck("early reset", 1'b0, device_reset);
        @(posedge clk);
        tick(1);
        repeat (4) @(negedge clk);
        ck("reset", 1'b1, device_reset);
        @(posedge clk);
        tick(0);
        for (int i = 0; i < 10; i++) tick(KEY[i]);
        od_x <= 3'h4;
        pa_x <= 8'h3C;
        pullup_port_b_in <= 8'hA5;
        open_drain_latch <= 3'h0;
        pullup_port_b_latch <= 8'h00;
        repeat (8) @(negedge clk);
        ck("prog", 1'b1, prog_state);
        ck("reset end", 1'b0, device_reset);
        ck("program mode", 1'b0, verify_mode);
        @(posedge clk);
        od_x <= 3'h5;
        pullup_port_b_in <= 8'hFE;
        repeat (6) @(negedge clk);
        ck("addr", 11'h6A5, eprom_addr);
        ck("data", 8'h3C, prog_data);
        @(posedge clk);
        od_x <= 3'h7;
        repeat (8) @(negedge clk);
        ck("verify mode", 1'b1, verify_mode);
        ck("verify", 8'hC3, pullup_port_a_read);
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(negedge clk);
        ck("reprog", 1'b0, prog_state);
        ck("remode", 1'b1, verify_mode);
        give_verdict;
    end
    // Whole run is near 200 clocks
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        give_verdict;
    end
endmodule // ppe_port_pins_test
bind ppe_port_pins ppe_chk chk_i (
    .clk(clk), .rst(rst), .open_drain_port_oe(open_drain_port_oe),
    .open_drain_latch(open_drain_latch), .pullup_port_a_oe(pullup_port_a_oe),
    .pullup_port_b_oe(pullup_port_b_oe), .prog_state(prog_state), .verify_mode(verify_mode)
);
`default_nettype wire

/* common/ppe_regs.vh */
// Constants for the port pins and program entry block
`ifndef PPE_REGS_VH
`define PPE_REGS_VH
`define PPE_RST_QUAL_OSC 24
`define PPE_KEY_BITS 4'hA
`define PPE_KEY_PATTERN 10'h2A5
`define PPE_SCL_BIT 0
`define PPE_SDA_BIT 1
`define PPE_ADDRESS_BYTE_SELECT_BIT 0
`define PPE_VPS_BIT 1
`define PPE_IRQA_BIT 5
`define PPE_IRQB_BIT 6
`define PPE_CNT_BIT 7
`define PPE_HI_ADDR_BITS 3
`endif

/* hw/ppe_port_pins.v */
// Port pins, reset qualification and programming-state entry
// Notes on behaviour
// - Three-bit open-drain port floats when written one
// - Open-drain pin low if latch or I2C zero, except in programming state
// - Open-drain port read returns pin levels
// - I2C mode: bit 0 clock, bit 1 data
// - Pull-up port A: ones pulled high, inputs
// - Port A bits 5,6 irqs; bit 7 counter
// - Pull-up port B behaves like port A
// - Reset pin high two machine cycles resets
// - Reset qualification counts 24 oscillator clocks
// - Ten-bit key LSB first enters programming
// - Select high verify, low program
// - Address select picks low or high byte
// - Eleven-bit address assembled from port B
// - Verify drives port A; program reads it
`include "ppe_regs.vh"
`default_nettype none
module ppe_port_pins #(
    parameter RST_QUAL = `PPE_RST_QUAL_OSC,
    parameter [9:0] KEY = `PPE_KEY_PATTERN
) (
    input wire clk,
    input wire rst,
    input wire osc_input_clock,
    input wire reset_pin,
    input wire [2:0] open_drain_port_in,
    output wire [2:0] open_drain_port_out,
    output wire [2:0] open_drain_port_oe,
    input wire [2:0] open_drain_latch,
    input wire i2c_enable,
    input wire i2c_scl_drive,
    input wire i2c_sda_drive,
    output reg [2:0] open_drain_port_read,
    input wire [7:0] pullup_port_a_in,
    output wire [7:0] pullup_port_a_out,
    output wire [7:0] pullup_port_a_oe,
    input wire [7:0] pullup_port_a_latch,
    output reg [7:0] pullup_port_a_read,
    output reg ext_irq_a,
    output reg ext_irq_b,
    output reg counter_ext_input,
    input wire [7:0] pullup_port_b_in,
    output wire [7:0] pullup_port_b_out,
    output wire [7:0] pullup_port_b_oe,
    input wire [7:0] pullup_port_b_latch,
    output reg [7:0] pullup_port_b_read,
    output reg device_reset,
    output reg prog_state,
    output reg verify_mode,
    output reg [10:0] eprom_addr,
    output reg [7:0] prog_data,
    input wire [7:0] eprom_rdata
);
// ==========================================================
// Input synchronisers
// Oscillator pin is sampled, so it must run under half the clk rate
reg [2:0] od_s1;
reg [2:0] od_s2;
reg [7:0] pa_s1;
reg [7:0] pa_s2;
reg [7:0] pb_s1;
reg [7:0] pb_s2;
reg rp_s1;
reg rp_s2;
reg ck_s1;
reg ck_s2;
reg ck_d;
always @(posedge clk) begin
    od_s1 <= open_drain_port_in;
    od_s2 <= od_s1;
    pa_s1 <= pullup_port_a_in;
    pa_s2 <= pa_s1;
    pb_s1 <= pullup_port_b_in;
    pb_s2 <= pb_s1;
    rp_s1 <= reset_pin;
    rp_s2 <= rp_s1;
    ck_s1 <= osc_input_clock;
    ck_s2 <= ck_s1;
    ck_d <= ck_s2;
end
wire osc_rise = ck_s2 & ~ck_d;
// ==========================================================
// Pin drivers
reg [2:0] od_low;
always @* begin
    od_low = ~open_drain_latch;
    if (i2c_enable && !prog_state) begin
        od_low[`PPE_SCL_BIT] = od_low[`PPE_SCL_BIT] | ~i2c_scl_drive;
        od_low[`PPE_SDA_BIT] = od_low[`PPE_SDA_BIT] | ~i2c_sda_drive;
    end
    // Programming state hands every open-drain pin to the programmer
    if (prog_state)
        od_low = 3'h0;
end
assign open_drain_port_out = 3'h0;
assign open_drain_port_oe = od_low;
// Quasi-bidirectional: a one leaves the pin to the pull-up
wire drive_a = prog_state & verify_mode;
assign pullup_port_a_out = drive_a ? eprom_rdata : 8'h00;
assign pullup_port_a_oe = drive_a ? 8'hFF : (prog_state ? 8'h00 : ~pullup_port_a_latch);
assign pullup_port_b_out = 8'h00;
assign pullup_port_b_oe = prog_state ? 8'h00 : ~pullup_port_b_latch;
// ==========================================================
// Pin reads and alternate inputs
always @(posedge clk) begin
    if (rst) begin
        open_drain_port_read <= 3'h7;
        pullup_port_a_read <= 8'hFF;
        pullup_port_b_read <= 8'hFF;
        ext_irq_a <= 1'b1;
        ext_irq_b <= 1'b1;
        counter_ext_input <= 1'b1;
    end else begin
        open_drain_port_read <= od_s2;
        pullup_port_a_read <= pa_s2;
        pullup_port_b_read <= pb_s2;
        ext_irq_a <= pa_s2[`PPE_IRQA_BIT];
        ext_irq_b <= pa_s2[`PPE_IRQB_BIT];
        counter_ext_input <= pa_s2[`PPE_CNT_BIT];
    end
end
// ==========================================================
// Reset qualification and key entry
// Serial key enters at the top, so the first bit ends at bit 0
function [9:0] key_shift;
    input [9:0] held;
    input in_bit;
    begin
        key_shift = {in_bit, held[9:1]};
    end
endfunction
// Entry sequence: idle, held in reset, key, programming
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_HELD = 2'b01;
localparam [1:0] ST_KEY = 2'b10;
localparam [1:0] ST_PROG = 2'b11;
reg [4:0] qual_cnt;
reg [9:0] key_sr;
reg [3:0] key_cnt;
reg [1:0] entry_state;
wire [9:0] key_next = key_shift(key_sr, rp_s2);
wire key_last = (key_cnt == `PPE_KEY_BITS - 4'h1);
wire qual_done = (qual_cnt == RST_QUAL[4:0] - 5'h01);
always @(posedge clk) begin
    if (rst) begin
        entry_state <= ST_IDLE;
        qual_cnt <= 5'h00;
        key_sr <= 10'h000;
        key_cnt <= 4'h0;
        device_reset <= 1'b0;
        prog_state <= 1'b0;
    end else if (osc_rise) begin
        // Only counts while the oscillator is seen running
        case (entry_state)
            ST_IDLE: begin
                if (!rp_s2)
                    qual_cnt <= 5'h00;
                else if (qual_done) begin
                    device_reset <= 1'b1;
                    entry_state <= ST_HELD;
                end else
                    qual_cnt <= qual_cnt + 5'h01;
            end
            ST_HELD: begin
                // First low rise ends reset and is not a key bit
                if (!rp_s2) begin
                    device_reset <= 1'b0;
                    qual_cnt <= 5'h00;
                    key_cnt <= 4'h0;
                    entry_state <= ST_KEY;
                end
            end
            ST_KEY: begin
                key_sr <= key_next;
                if (key_last) begin
                    key_cnt <= 4'h0;
                    // A wrong key needs a fresh qualified reset
                    if (key_next == KEY) begin
                        prog_state <= 1'b1;
                        entry_state <= ST_PROG;
                    end else
                        entry_state <= ST_IDLE;
                end else
                    key_cnt <= key_cnt + 4'h1;
            end
            ST_PROG: begin
                // Only rst leaves the programming state
                entry_state <= ST_PROG;
            end
            default: begin
                entry_state <= ST_IDLE;
            end
        endcase
    end
end
// ==========================================================
// Programming-state address and data capture
always @(posedge clk) begin
    if (rst) begin
        verify_mode <= 1'b1;
        eprom_addr <= 11'h000;
        prog_data <= 8'h00;
    end else if (prog_state) begin
        // Address halves latch each clock while the select stands
        verify_mode <= od_s2[`PPE_VPS_BIT];
        if (od_s2[`PPE_ADDRESS_BYTE_SELECT_BIT])
            eprom_addr[10:8] <= pb_s2[`PPE_HI_ADDR_BITS-1:0];
        else
            eprom_addr[7:0] <= pb_s2;
        if (!od_s2[`PPE_VPS_BIT])
            prog_data <= pa_s2;
    end
end
endmodule // ppe_port_pins
`default_nettype wire
